//--- hw/gse_pkg.sv
// Shared constants, types and register map of the graphics stream engine
package gse_pkg;
	// ------------------------------------------------------------
	// Datapath geometry
	// ------------------------------------------------------------
	localparam int GSE_AW = 20;
	localparam int GSE_DW = 96;
	localparam int GSE_LANES = 12;
	localparam logic [3:0] GSE_EPW8 = 4'hc;
	localparam logic [3:0] GSE_EPW16 = 4'h6;
	localparam int GSE_QDEPTH = 4;
	localparam logic [2:0] GSE_QFULL = 3'h4;
	localparam logic [1:0] GSE_BUF_FULL = 2'h2;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] GSE_OFF_CTRL = 8'h00;
	localparam logic [7:0] GSE_OFF_STATUS = 8'h04;
	localparam logic [7:0] GSE_OFF_FG = 8'h08;
	localparam logic [7:0] GSE_OFF_BG = 8'h0c;
	localparam logic [7:0] GSE_OFF_SCALAR = 8'h10;
	localparam logic [7:0] GSE_OFF_SRC_BASE = 8'h14;
	localparam logic [7:0] GSE_OFF_DST_BASE = 8'h18;
	localparam logic [7:0] GSE_OFF_PAT_BASE = 8'h1c;
	localparam logic [7:0] GSE_OFF_PITCH = 8'h20;
	localparam logic [7:0] GSE_OFF_SIZE = 8'h24;
	localparam logic [7:0] GSE_OFF_XSTEP = 8'h28;
	localparam logic [7:0] GSE_OFF_YSTEP = 8'h2c;
	localparam logic [7:0] GSE_OFF_CMD = 8'h30;
	// ------------------------------------------------------------
	// Control register fields and reset values
	// ------------------------------------------------------------
	localparam int GSE_CTRL_BPP16 = 0;
	localparam int GSE_CTRL_MONO_SRC = 1;
	localparam int GSE_CTRL_SRC_HOST = 2;
	localparam int GSE_CTRL_X_NEG = 3;
	localparam int GSE_CTRL_Y_NEG = 4;
	localparam int GSE_CTRL_SFACT = 5;
	localparam int GSE_CTRL_DFACT = 8;
	localparam int GSE_CTRL_INTERP = 11;
	localparam int GSE_CTRL_PEN = 12;
	localparam int GSE_CTRL_MASK_EN = 14;
	localparam int GSE_CTRL_MASK_ROP = 16;
	localparam int GSE_CTRL_ALPHA_PP = 24;
	localparam logic [31:0] GSE_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] GSE_STEP_RST = 32'h0001_0000;
	localparam int GSE_CMD_OP = 0;
	localparam int GSE_CMD_KIND = 4;
	localparam int GSE_CMD_ROP = 8;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		GSE_OP_FILL = 4'h0, GSE_OP_COPY = 4'h1, GSE_OP_ROP = 4'h2, GSE_OP_ADD = 4'h3, GSE_OP_SUB = 4'h4,
		GSE_OP_BLEND = 4'h5, GSE_OP_SCALAR_ADD_OP = 4'h6, GSE_OP_SCALAR_SUBTRACT_OP = 4'h7, GSE_OP_STRETCH = 4'h8
	} gse_op_t;
	typedef enum logic [1:0] {GSE_K_RECT = 2'h0, GSE_K_SPAN = 2'h1, GSE_K_LINE = 2'h2} gse_kind_t;
	typedef enum logic [2:0] {
		GSE_F_ZERO = 3'h0, GSE_F_ONE = 3'h1, GSE_F_SA = 3'h2, GSE_F_INV_SA = 3'h3, GSE_F_DA = 3'h4, GSE_F_INV_DA = 3'h5
	} gse_factor_t;
	typedef enum logic [2:0] {
		GSE_S_IDLE = 3'h0, GSE_S_LDPAT = 3'h1, GSE_S_ROW = 3'h2, GSE_S_ADDR = 3'h3,
		GSE_S_LDSRC = 3'h4, GSE_S_LDDST = 3'h5, GSE_S_EXEC = 3'h6
	} gse_state_t;
	typedef struct packed {
		logic [GSE_AW-1:0] addr;
		logic [GSE_DW-1:0] data;
		logic [GSE_LANES-1:0] be;
	} gse_fbwr_t;
endpackage

//--- hw/gse_stream_engine.sv
// Graphics stream engine: APB render state, instruction queue, span setup and vector datapath
`timescale 1ns/1ns
// Function
// - One latched opcode applied to every element
// - Mono source bit picks foreground or background
// - Scalar add and subtract per source element
// - Span ignores pitch, rectangle honours pitch
// - Setup splits rectangles and lines into spans
// - 96-bit memory path, staged address/load/execute
// - Six blend factors from zero to inverse dst
// - Factors applied separately to source and destination
// - Pattern is 8x8 brush or 32x1 pen
// - Mono expansion to 8 or 16 bpp
// - Opaque writes all; transparent compares colours
// - Programmable start corner for overlapping transfers
// - All 256 raster codes plus transparent variants
// - Source from frame buffer or host stream
// - Any operand combination for data and mask
// - Expansion only for source and pattern
// - Stretch by DDA stepping, replicate or interpolate
// - Commands arrive as queued instructions
module gse_stream_engine (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Frame buffer reads
	output logic mem_rd_valid,
	input wire logic mem_rd_ready,
	output logic [gse_pkg::GSE_AW-1:0] mem_rd_addr,
	input wire logic mem_rd_data_valid,
	input wire logic [gse_pkg::GSE_DW-1:0] mem_rd_data,
	// Frame buffer writes
	output logic mem_wr_valid,
	input wire logic mem_wr_ready,
	output gse_pkg::gse_fbwr_t mem_wr,
	// Host source stream
	input wire logic host_src_valid,
	output logic host_src_ready,
	input wire logic [gse_pkg::GSE_DW-1:0] host_src_data,
	// Status
	output logic busy
);
	import gse_pkg::*;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [31:0] ctrl_reg, pitch_reg, size_reg, xstep_reg, ystep_reg, prdata_reg;
	logic [15:0] fg_reg, bg_reg, scalar_reg;
	logic [GSE_AW-1:0] src_base_reg, dst_base_reg, pat_base_reg;
	logic [31:0] q_mem [GSE_QDEPTH];
	logic [1:0] q_wptr_reg, q_rptr_reg;
	logic [2:0] q_cnt_reg;
	logic [1:0] buf_cnt_reg;
	gse_state_t state_reg;
	logic mapped, wr_en, q_push, q_pop;

	always_comb begin
		case (paddr)
			GSE_OFF_CTRL, GSE_OFF_STATUS, GSE_OFF_FG, GSE_OFF_BG, GSE_OFF_SCALAR, GSE_OFF_SRC_BASE,
			GSE_OFF_DST_BASE, GSE_OFF_PAT_BASE, GSE_OFF_PITCH, GSE_OFF_SIZE, GSE_OFF_XSTEP,
			GSE_OFF_YSTEP, GSE_OFF_CMD: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// A full queue holds the command write in wait states instead of dropping it
	assign pready = !(psel && pwrite && paddr == GSE_OFF_CMD && q_cnt_reg == GSE_QFULL);
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && pready && mapped;
	assign q_push = wr_en && paddr == GSE_OFF_CMD;
	assign q_pop = state_reg == GSE_S_IDLE && q_cnt_reg != 3'h0;
	assign prdata = prdata_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= GSE_CTRL_RST;
			fg_reg <= 16'h0000;
			bg_reg <= 16'h0000;
			scalar_reg <= 16'h0000;
			src_base_reg <= '0;
			dst_base_reg <= '0;
			pat_base_reg <= '0;
			pitch_reg <= 32'h0000_0000;
			size_reg <= 32'h0000_0000;
			xstep_reg <= GSE_STEP_RST;
			ystep_reg <= GSE_STEP_RST;
		end else if (wr_en) begin
			case (paddr)
				GSE_OFF_CTRL: ctrl_reg <= pwdata;
				GSE_OFF_FG: fg_reg <= pwdata[15:0];
				GSE_OFF_BG: bg_reg <= pwdata[15:0];
				GSE_OFF_SCALAR: scalar_reg <= pwdata[15:0];
				GSE_OFF_SRC_BASE: src_base_reg <= pwdata[GSE_AW-1:0];
				GSE_OFF_DST_BASE: dst_base_reg <= pwdata[GSE_AW-1:0];
				GSE_OFF_PAT_BASE: pat_base_reg <= pwdata[GSE_AW-1:0];
				GSE_OFF_PITCH: pitch_reg <= pwdata;
				GSE_OFF_SIZE: size_reg <= pwdata;
				GSE_OFF_XSTEP: xstep_reg <= pwdata;
				GSE_OFF_YSTEP: ystep_reg <= pwdata;
				default: ;
			endcase
		end
	end

	// Read data is sampled in the setup cycle so it is a flop during the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				GSE_OFF_CTRL: prdata_reg <= ctrl_reg;
				GSE_OFF_STATUS: prdata_reg <= {26'h0, buf_cnt_reg, q_cnt_reg, busy};
				GSE_OFF_FG: prdata_reg <= {16'h0, fg_reg};
				GSE_OFF_BG: prdata_reg <= {16'h0, bg_reg};
				GSE_OFF_SCALAR: prdata_reg <= {16'h0, scalar_reg};
				GSE_OFF_SRC_BASE: prdata_reg <= {12'h0, src_base_reg};
				GSE_OFF_DST_BASE: prdata_reg <= {12'h0, dst_base_reg};
				GSE_OFF_PAT_BASE: prdata_reg <= {12'h0, pat_base_reg};
				GSE_OFF_PITCH: prdata_reg <= pitch_reg;
				GSE_OFF_SIZE: prdata_reg <= size_reg;
				GSE_OFF_XSTEP: prdata_reg <= xstep_reg;
				GSE_OFF_YSTEP: prdata_reg <= ystep_reg;
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Instruction queue
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_wptr_reg <= 2'h0;
			q_rptr_reg <= 2'h0;
			q_cnt_reg <= 3'h0;
		end else begin
			if (q_push) begin
				q_wptr_reg <= q_wptr_reg + 2'h1;
			end
			if (q_pop) begin
				q_rptr_reg <= q_rptr_reg + 2'h1;
			end
			q_cnt_reg <= q_cnt_reg + {2'h0, q_push} - {2'h0, q_pop};
		end
	end

	always_ff @(posedge pclk) begin
		if (q_push) begin
			q_mem[q_wptr_reg] <= pwdata;
		end
	end

	// ------------------------------------------------------------
	// Setup sequencer and load/store stages
	// ------------------------------------------------------------
	logic [31:0] cmd_reg;
	logic [11:0] rcnt_reg, ccnt_reg, row_reg, col_reg;
	logic [GSE_AW-1:0] src_addr_reg, dst_addr_reg;
	logic [GSE_DW-1:0] src_w_reg, dst_w_reg, pat_w_reg;
	logic rd_req_reg, rd_wait_reg, rd_done, src_done, buf_in_ready;
	gse_op_t op;
	gse_kind_t kind;
	logic [11:0] w_words, h_rows, row_act, col_act, src_row, src_col, dst_col, dstride, sstride;
	logic [43:0] prod_dc, prod_sr, prod_sc;

	assign op = gse_op_t'(cmd_reg[GSE_CMD_OP +: 4]);
	assign kind = gse_kind_t'(cmd_reg[GSE_CMD_KIND +: 2]);
	assign w_words = kind == GSE_K_LINE ? 12'h001 : size_reg[11:0];
	assign h_rows = size_reg[27:16];
	assign busy = state_reg != GSE_S_IDLE;
	assign rd_done = rd_wait_reg && mem_rd_data_valid;
	assign host_src_ready = state_reg == GSE_S_LDSRC && ctrl_reg[GSE_CTRL_SRC_HOST];
	assign src_done = ctrl_reg[GSE_CTRL_SRC_HOST] ? host_src_valid : rd_done;
	assign buf_in_ready = buf_cnt_reg != GSE_BUF_FULL;

	// Start corner: walk rows and columns backwards when requested
	assign row_act = ctrl_reg[GSE_CTRL_Y_NEG] ? h_rows - 12'h001 - rcnt_reg : rcnt_reg;
	assign col_act = ctrl_reg[GSE_CTRL_X_NEG] ? w_words - 12'h001 - ccnt_reg : ccnt_reg;
	assign prod_dc = 44'(row_reg) * 44'(xstep_reg);
	assign prod_sr = 44'(row_reg) * 44'(ystep_reg);
	assign prod_sc = 44'(col_reg) * 44'(xstep_reg);
	// A line steps its single-word span sideways by the slope on each row
	assign dst_col = kind == GSE_K_LINE ? prod_dc[27:16] : col_reg;
	assign src_row = op == GSE_OP_STRETCH ? prod_sr[27:16] : row_reg;
	assign src_col = op == GSE_OP_STRETCH ? prod_sc[27:16] : col_reg;
	assign dstride = kind == GSE_K_SPAN ? w_words : pitch_reg[27:16];
	assign sstride = kind == GSE_K_SPAN ? w_words : pitch_reg[11:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= GSE_S_IDLE;
			cmd_reg <= 32'h0000_0000;
			rcnt_reg <= 12'h000;
			ccnt_reg <= 12'h000;
			row_reg <= 12'h000;
			col_reg <= 12'h000;
			src_addr_reg <= '0;
			dst_addr_reg <= '0;
		end else begin
			case (state_reg)
				GSE_S_IDLE: begin
					if (q_pop) begin
						cmd_reg <= q_mem[q_rptr_reg];
						rcnt_reg <= 12'h000;
						state_reg <= GSE_S_LDPAT;
					end
				end
				GSE_S_LDPAT: begin
					if (rd_done) begin
						state_reg <= (h_rows == 12'h000 || w_words == 12'h000) ? GSE_S_IDLE : GSE_S_ROW;
					end
				end
				GSE_S_ROW: begin
					row_reg <= row_act;
					ccnt_reg <= 12'h000;
					state_reg <= GSE_S_ADDR;
				end
				GSE_S_ADDR: begin
					col_reg <= col_act;
					state_reg <= GSE_S_LDSRC;
				end
				GSE_S_LDSRC: begin
					// Addresses use row latched in GSE_S_ROW and col latched in GSE_S_ADDR
					dst_addr_reg <= dst_base_reg + GSE_AW'(row_reg * dstride) + GSE_AW'(dst_col);
					src_addr_reg <= src_base_reg + GSE_AW'(src_row * sstride) + GSE_AW'(src_col);
					if (src_done || op == GSE_OP_FILL) begin
						state_reg <= GSE_S_LDDST;
					end
				end
				GSE_S_LDDST: begin
					if (rd_done) begin
						state_reg <= GSE_S_EXEC;
					end
				end
				GSE_S_EXEC: begin
					if (buf_in_ready) begin
						if (ccnt_reg + 12'h001 < w_words) begin
							ccnt_reg <= ccnt_reg + 12'h001;
							state_reg <= GSE_S_ADDR;
						end else if (rcnt_reg + 12'h001 < h_rows) begin
							rcnt_reg <= rcnt_reg + 12'h001;
							state_reg <= GSE_S_ROW;
						end else begin
							state_reg <= GSE_S_IDLE;
						end
					end
				end
				default: state_reg <= GSE_S_IDLE;
			endcase
		end
	end

	// Read request channel: one outstanding 96-bit read at a time
	logic rd_state, rd_start;
	assign rd_state = state_reg == GSE_S_LDPAT || state_reg == GSE_S_LDDST ||
		(state_reg == GSE_S_LDSRC && !ctrl_reg[GSE_CTRL_SRC_HOST] && op != GSE_OP_FILL);
	assign rd_start = rd_state && !rd_req_reg && !rd_wait_reg;
	assign mem_rd_valid = rd_req_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_req_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			mem_rd_addr <= '0;
		end else begin
			if (rd_start) begin
				rd_req_reg <= 1'b1;
				mem_rd_addr <= state_reg == GSE_S_LDPAT ? pat_base_reg :
					(state_reg == GSE_S_LDSRC ? src_base_reg + GSE_AW'(src_row * sstride) + GSE_AW'(src_col) :
					dst_addr_reg);
			end else if (rd_req_reg && mem_rd_ready) begin
				rd_req_reg <= 1'b0;
				rd_wait_reg <= 1'b1;
			end else if (rd_done) begin
				rd_wait_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_w_reg <= '0;
			dst_w_reg <= '0;
			pat_w_reg <= '0;
		end else begin
			if (state_reg == GSE_S_LDPAT && rd_done) begin
				pat_w_reg <= mem_rd_data;
			end
			if (state_reg == GSE_S_LDSRC && src_done) begin
				src_w_reg <= ctrl_reg[GSE_CTRL_SRC_HOST] ? host_src_data : mem_rd_data;
			end
			if (state_reg == GSE_S_LDDST && rd_done) begin
				dst_w_reg <= mem_rd_data;
			end
		end
	end

	// ------------------------------------------------------------
	// Execution lanes, one per byte of the memory word
	// ------------------------------------------------------------
	logic [GSE_DW-1:0] res_data;
	logic [GSE_LANES-1:0] res_be, s_key, d_eq;
	logic bpp16;
	logic [3:0] epw;
	logic [7:0] scal, salpha;
	assign bpp16 = ctrl_reg[GSE_CTRL_BPP16];
	assign epw = bpp16 ? GSE_EPW16 : GSE_EPW8;
	assign scal = scalar_reg[7:0];
	assign salpha = scalar_reg[15:8];

	function automatic logic [7:0] blend_factor(input logic [2:0] sel, input logic [7:0] sa, input logic [7:0] da);
		case (gse_factor_t'(sel))
			GSE_F_ZERO: blend_factor = 8'h00;
			GSE_F_ONE: blend_factor = 8'hff;
			GSE_F_SA: blend_factor = sa;
			GSE_F_INV_SA: blend_factor = ~sa;
			GSE_F_DA: blend_factor = da;
			GSE_F_INV_DA: blend_factor = ~da;
			default: blend_factor = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] sat8(input logic [9:0] v);
		// Sign bit set means underflow, bit 8 means overflow
		sat8 = v[9] ? 8'h00 : (v[8] ? 8'hff : v[7:0]);
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < GSE_LANES; gi++) begin : g_lane
			localparam logic ODD = 1'(gi % 2);
			logic [3:0] pix, sp, sp1;
			logic [35:0] sprod;
			logic [15:0] x_px;
			logic [7:0] fgb, bgb, s_raw, s_nxt, s_str, s, d, p, sa, da, fs, fd, rop_out, r;
			logic [16:0] bsum, bnorm;
			logic pbit, mono_bit, mask;
			always_comb begin
				pix = bpp16 ? 4'(gi / 2) : 4'(gi);
				fgb = (bpp16 && ODD) ? fg_reg[15:8] : fg_reg[7:0];
				bgb = (bpp16 && ODD) ? bg_reg[15:8] : bg_reg[7:0];
				// Stretch: element j takes source element floor(j*step) inside the word
				sprod = 36'(pix) * 36'(xstep_reg);
				sp = (op == GSE_OP_STRETCH) ? ((sprod[35:16] >= 20'(epw)) ? epw - 4'h1 : sprod[19:16]) : pix;
				sp1 = (sp == epw - 4'h1) ? sp : sp + 4'h1;
				s_raw = src_w_reg[{(bpp16 ? {sp[2:0], ODD} : sp), 3'b000} +: 8];
				s_nxt = src_w_reg[{(bpp16 ? {sp1[2:0], ODD} : sp1), 3'b000} +: 8];
				s_str = ctrl_reg[GSE_CTRL_INTERP] ? 8'((9'(s_raw) + 9'(s_nxt)) >> 1) : s_raw;
				mono_bit = src_w_reg[pix];
				// Only source and pattern are expanded; destination is used as stored
				s = ctrl_reg[GSE_CTRL_MONO_SRC] ? (mono_bit ? fgb : bgb) : s_str;
				d = dst_w_reg[gi*8 +: 8];
				x_px = 16'(dst_col * 12'(epw)) + 16'(pix);
				pbit = ctrl_reg[GSE_CTRL_PEN] ? pat_w_reg[x_px[4:0]] : pat_w_reg[{row_reg[2:0], x_px[2:0]}];
				p = pbit ? fgb : bgb;
				sa = (ctrl_reg[GSE_CTRL_ALPHA_PP] && bpp16) ? src_w_reg[(gi | 1)*8 +: 8] : salpha;
				da = (ctrl_reg[GSE_CTRL_ALPHA_PP] && bpp16) ? dst_w_reg[(gi | 1)*8 +: 8] : salpha;
				fs = blend_factor(ctrl_reg[GSE_CTRL_SFACT +: 3], sa, da);
				fd = blend_factor(ctrl_reg[GSE_CTRL_DFACT +: 3], sa, da);
				bsum = 17'(16'(s) * 16'(fs)) + 17'(16'(d) * 16'(fd));
				// Divide by 255, not 256, so that a factor of one passes a component unchanged
				bnorm = bsum + 17'(bsum[16:8]) + 17'h00001;
				for (int k = 0; k < 8; k++) begin
					rop_out[k] = cmd_reg[GSE_CMD_ROP + int'({p[k], s[k], d[k]})];
				end
				case (op)
					GSE_OP_FILL: r = fgb;
					GSE_OP_COPY, GSE_OP_STRETCH: r = s;
					GSE_OP_ROP: r = rop_out;
					GSE_OP_ADD: r = sat8(10'(s) + 10'(d));
					GSE_OP_SUB: r = sat8(10'(s) - 10'(d));
					GSE_OP_BLEND: r = (bnorm[16:8] > 9'h0ff) ? 8'hff : bnorm[15:8];
					GSE_OP_SCALAR_ADD_OP: r = sat8(10'(s) + 10'(scal));
					GSE_OP_SCALAR_SUBTRACT_OP: r = sat8(10'(s) - 10'(scal));
					default: r = s;
				endcase
			end
			assign s_key[gi] = s == bgb;
			assign d_eq[gi] = d == s;
			// A 16-bit pixel matches only when both of its bytes match
			assign mask = ctrl_reg[GSE_CTRL_MASK_ROP + int'({pbit,
				bpp16 ? (s_key[gi] && s_key[gi ^ 1]) : s_key[gi],
				bpp16 ? (d_eq[gi] && d_eq[gi ^ 1]) : d_eq[gi]})];
			assign res_data[gi*8 +: 8] = r;
			assign res_be[gi] = ctrl_reg[GSE_CTRL_MASK_EN] ? mask : 1'b1;
		end
	endgenerate

	// ------------------------------------------------------------
	// Two-entry write buffer towards the frame buffer
	// ------------------------------------------------------------
	gse_fbwr_t buf_mem [2];
	logic buf_wptr_reg, buf_rptr_reg, buf_push, buf_pop;
	assign buf_push = state_reg == GSE_S_EXEC && buf_in_ready;
	assign buf_pop = mem_wr_valid && mem_wr_ready;
	assign mem_wr_valid = buf_cnt_reg != 2'h0;
	assign mem_wr = buf_mem[buf_rptr_reg];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_wptr_reg <= 1'b0;
			buf_rptr_reg <= 1'b0;
			buf_cnt_reg <= 2'h0;
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end else begin
			if (buf_push) begin
				buf_mem[buf_wptr_reg] <= '{addr: dst_addr_reg, data: res_data, be: res_be};
				buf_wptr_reg <= ~buf_wptr_reg;
			end
			if (buf_pop) begin
				buf_rptr_reg <= ~buf_rptr_reg;
			end
			buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_exec(gse_op_t o);
		state_reg == GSE_S_EXEC && op == o && !bpp16;
	endsequence
	AST_OP_FILL: assert property (s_exec(GSE_OP_FILL) |-> res_data[7:0] == fg_reg[7:0])
		else $error("fill lane does not carry foreground");
	AST_MONO_SEL: assert property (s_exec(GSE_OP_COPY) ##0 ctrl_reg[GSE_CTRL_MONO_SRC]
		|-> res_data[7:0] == (src_w_reg[0] ? fg_reg[7:0] : bg_reg[7:0]))
		else $error("mono source selects wrong colour");
	AST_SCALAR_ADD_OP_SAT: assert property (s_exec(GSE_OP_SCALAR_ADD_OP) ##0 !ctrl_reg[GSE_CTRL_MONO_SRC]
		|-> res_data[7:0] == ((9'(src_w_reg[7:0]) + 9'(scal) > 9'h0ff) ? 8'hff : 8'(src_w_reg[7:0] + scal)))
		else $error("scalar add wrong or not saturated");
	AST_SPAN_ADDR: assert property (state_reg == GSE_S_LDDST && kind == GSE_K_SPAN
		|-> dst_addr_reg == dst_base_reg + GSE_AW'(row_reg * w_words) + GSE_AW'(col_reg))
		else $error("span address uses pitch");
	AST_BLEND_ONE: assert property (s_exec(GSE_OP_BLEND) ##0 ctrl_reg[GSE_CTRL_SFACT +: 3] == GSE_F_ZERO
		##0 ctrl_reg[GSE_CTRL_DFACT +: 3] == GSE_F_ONE |-> res_data[7:0] == dst_w_reg[7:0])
		else $error("zero/one blend wrong");
	AST_ROP_SRC: assert property (s_exec(GSE_OP_ROP) ##0 cmd_reg[GSE_CMD_ROP +: 8] == 8'hcc
		##0 !ctrl_reg[GSE_CTRL_MONO_SRC] |-> res_data == src_w_reg)
		else $error("source copy raster code wrong");
	AST_OPAQUE: assert property (buf_push && !ctrl_reg[GSE_CTRL_MASK_EN] |=> mem_wr_valid ##0 buf_cnt_reg != 2'h0
		##0 (&buf_mem[~buf_wptr_reg].be))
		else $error("opaque write masked");
	AST_CORNER: assert property (state_reg == GSE_S_ROW && rcnt_reg == 12'h000 && ctrl_reg[GSE_CTRL_Y_NEG]
		|=> row_reg == h_rows - 12'h001)
		else $error("bottom-up start row wrong");
	AST_WR_HOLD: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr))
		else $error("write request dropped under stall");
	AST_QUEUE: assert property (q_push && !q_pop |=> q_cnt_reg == $past(q_cnt_reg) + 3'h1)
		else $error("queued instruction lost");
endmodule

//--- bench/gse_fb_model.sv
// Frame buffer model that answers engine reads and takes its writes
`timescale 1ns/1ns
module gse_fb_model (
	// Clock, reset and write stall
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stall,
	// Engine side
	input wire logic mem_rd_valid,
	output logic mem_rd_ready,
	input wire logic [gse_pkg::GSE_AW-1:0] mem_rd_addr,
	output logic mem_rd_data_valid,
	output logic [gse_pkg::GSE_DW-1:0] mem_rd_data,
	input wire logic mem_wr_valid,
	output logic mem_wr_ready,
	input wire gse_pkg::gse_fbwr_t mem_wr
);
	import gse_pkg::*;
	logic [GSE_DW-1:0] mem [64];
	int wr_cnt;
	assign mem_rd_ready = 1'b1;
	assign mem_wr_ready = !stall;
	// Idle read data is inverted so a stale word never passes for a fresh one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_rd_data_valid <= 1'b0;
			mem_rd_data <= '0;
			wr_cnt <= 0;
		end else begin
			mem_rd_data_valid <= mem_rd_valid;
			mem_rd_data <= mem_rd_valid ? mem[mem_rd_addr[5:0]] : ~mem_rd_data;
			if (mem_wr_valid && !stall) begin
				for (int i = 0; i < GSE_LANES; i++) begin
					if (mem_wr.be[i])
						mem[mem_wr.addr[5:0]][8*i+:8] <= mem_wr.data[8*i+:8];
				end
				wr_cnt <= wr_cnt + 1;
			end
		end
	end
endmodule

//--- bench/gse_stream_engine_tb.sv
// Self-checking bench for the graphics stream engine
`timescale 1ns/1ns
module gse_stream_engine_tb;
	import gse_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, stall, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic mem_rd_valid, mem_rd_ready, mem_rd_data_valid, mem_wr_valid, mem_wr_ready, host_src_valid, host_src_ready;
	logic [GSE_AW-1:0] mem_rd_addr;
	logic [GSE_DW-1:0] mem_rd_data, host_src_data;
	gse_fbwr_t mem_wr;
	int mismatches, n_compared;
	int n_host = 0;
	gse_stream_engine u_gse_stream_engine (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .mem_rd_valid, .mem_rd_ready, .mem_rd_addr, .mem_rd_data_valid, .mem_rd_data,
		.mem_wr_valid, .mem_wr_ready, .mem_wr, .host_src_valid, .host_src_ready, .host_src_data, .busy);
	gse_fb_model u_gse_fb_model (.pclk, .presetn, .stall, .mem_rd_valid, .mem_rd_ready, .mem_rd_addr,
		.mem_rd_data_valid, .mem_rd_data, .mem_wr_valid, .mem_wr_ready, .mem_wr);
	// ------------------------------------------------------------
	// Bus tasks and tests
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// The answer is taken at the rising edge where pready is seen high
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Host words actually handed over
	always @(posedge pclk) begin
		if (host_src_valid && host_src_ready)
			n_host <= n_host + 1;
	end
	task automatic chk(input string n, input logic [95:0] s, input logic [95:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic run(input string n, input logic [31:0] ctrl, input logic [31:0] cmd, input logic [95:0] s,
		input logic [95:0] e);
		int c;
		u_gse_fb_model.mem[1] = s;
		apb(1'b1, GSE_OFF_CTRL, ctrl);
		c = u_gse_fb_model.wr_cnt;
		apb(1'b1, GSE_OFF_CMD, cmd);
		if (stall) begin
			repeat (40) @(negedge pclk);
			chk("held", {mem_wr_valid, 1'(u_gse_fb_model.wr_cnt == c)}, 2'h3);
			@(posedge pclk);
			stall <= 1'b0;
		end
		do @(negedge pclk); while (u_gse_fb_model.wr_cnt == c || busy !== 1'b0);
		chk(n, u_gse_fb_model.mem[2], e);
		$display("test %s done", n);
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, stall, host_src_valid, host_src_data} = '0;
		u_gse_fb_model.mem[3] = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, GSE_OFF_CTRL, 32'h0);
		chk("ctrl", rd, GSE_CTRL_RST);
		apb(1'b0, GSE_OFF_XSTEP, 32'h0);
		chk("xstep", rd, GSE_STEP_RST);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", {err, rd}, 33'h1_0000_0000);
		apb(1'b1, GSE_OFF_SRC_BASE, 32'h1);
		apb(1'b1, GSE_OFF_DST_BASE, 32'h2);
		apb(1'b1, GSE_OFF_PAT_BASE, 32'h3);
		apb(1'b1, GSE_OFF_SIZE, 32'h0001_0001);
		apb(1'b1, GSE_OFF_FG, 32'haa);
		apb(1'b1, GSE_OFF_BG, 32'h55);
		apb(1'b1, GSE_OFF_SCALAR, 32'h20);
		apb(1'b0, GSE_OFF_FG, 32'h0);
		chk("fg", rd, 32'haa);
		run("copy", 32'h0, 32'h1, 96'h0123_4567_89ab_cdef_0011_2233, 96'h0123_4567_89ab_cdef_0011_2233);
		run("blend", 32'h100, 32'h5, 96'h0, 96'h0123_4567_89ab_cdef_0011_2233);
		run("rop", 32'h0, 32'hcc02, 96'hfedc_ba98_7654_3210_ffee_ddcc, 96'hfedc_ba98_7654_3210_ffee_ddcc);
		run("span", 32'h0, 32'h11, 96'h0123_4567_89ab_cdef_0011_2233, 96'h0123_4567_89ab_cdef_0011_2233);
		run("corner", 32'h18, 32'h1, 96'hfedc_ba98_7654_3210_ffee_ddcc, 96'hfedc_ba98_7654_3210_ffee_ddcc);
		run("scalar_add_op", 32'h0, 32'h6, {{11{8'hf0}}, 8'h10}, {{11{8'hff}}, 8'h30});
		run("scalar_subtract_op", 32'h0, 32'h7, {{11{8'hf0}}, 8'h10}, {{11{8'hd0}}, 8'h00});
		run("mono", 32'h2, 32'h1, 96'h5, {{9{8'h55}}, 8'haa, 8'h55, 8'haa});
		@(posedge pclk);
		host_src_data <= 96'h1234_5678_9abc_def0_0fed_cba9;
		host_src_valid <= 1'b1;
		stall <= 1'b1;
		run("host", 32'h4, 32'h1, 96'h0, 96'h1234_5678_9abc_def0_0fed_cba9);
		chk("host_words", n_host, 96'h1);
		@(posedge pclk);
		host_src_valid <= 1'b0;
		host_src_data <= ~host_src_data;
		end_of_test();
	end
endmodule
